// >>> rtl/scpi_status_pkg.sv
// Constants shared by the SCPI status register bank and its groups.
// Assumes one clock and a power-on reset common to every user.
// What this block does
// - Condition query returns condition bits 0..14 and leaves them unchanged.
// - Enable registers are read/write; bit 15 always reads zero.
// - Event register read returns latched bits, then clears them.
// - Positive and negative filters are writable; top bit reads zero.
// - Rising condition with positive filter bit set sets the event bit.
// - Falling condition with negative filter bit set sets the event bit.
// - Both filter bits set: change either way sets the event bit.
// - Both filter bits clear: no condition change sets the event bit.
// - Filters preset at power-on and status preset only.
// - Event registers and error queue cleared by clear-status and power-on.
// - Enables and queue enable preset at power-on and status preset only.
// - Standard event and service request enables cleared only at power-on.
// - Standard event register and status byte cleared by clear-status, power-on.
// - Preset loads positive filters 0x7FFF; negative filters, enables zero.
// - Equipment condition bit 1 is one while a sensor is attached.
// - Equipment condition bit 3 is one while the sensor reports error.
// - Negative filter bit 1 set: sensor removal sets equipment event bit 1.
// - Positive filter bit 1 set: sensor attach sets equipment event bit 1.
// - Equipment bits 0, 2, 4-14 carry nothing; bit 15 always zero.
// - Enable bit gates its event onto the parent summary bit.
// - Operation group: calibrating bit 0, trigger-wait bit 5, sense bit 10.
package scpi_status_pkg;
   localparam int         GW             = 15;
   localparam int         NGRP           = 10;
   localparam logic [3:0] G_DEV          = 4'h0;
   localparam logic [3:0] G_OPER         = 4'h1;
   localparam logic [3:0] G_OCAL         = 4'h2;
   localparam logic [3:0] G_OLLF         = 4'h3;
   localparam logic [3:0] G_OSNS         = 4'h4;
   localparam logic [3:0] G_OTRG         = 4'h5;
   localparam logic [3:0] G_OULF         = 4'h6;
   localparam logic [3:0] G_QUES         = 4'h7;
   localparam logic [3:0] G_QCAL         = 4'h8;
   localparam logic [3:0] G_QPOW         = 4'h9;
   localparam logic [3:0] G_IEEE         = 4'hA;
   localparam logic [2:0] R_COND         = 3'h0;
   localparam logic [2:0] R_EVENT        = 3'h1;
   localparam logic [2:0] R_ENABLE       = 3'h2;
   localparam logic [2:0] R_PTR          = 3'h3;
   localparam logic [2:0] R_NTR          = 3'h4;
   localparam logic [2:0] R_STB          = 3'h0;
   localparam logic [2:0] R_ESR          = 3'h1;
   localparam logic [2:0] R_ESE          = 3'h2;
   localparam logic [2:0] R_SRE          = 3'h3;
   localparam logic [2:0] R_ERRQ         = 3'h4;
   localparam logic [2:0] R_ERRQ_EN      = 3'h5;
   localparam logic [14:0] PTR_PRESET    = 15'h7FFF;
   localparam logic [14:0] NTR_PRESET    = 15'h0000;
   localparam logic [14:0] EN_PRESET     = 15'h0000;
   localparam logic [15:0] ERRQ_EN_PRESET = 16'hFFFF;
   localparam int         DEV_SENSOR     = 1;
   localparam int         DEV_ERROR      = 3;
   localparam int         OPER_CAL       = 0;
   localparam int         OPER_TRIG      = 5;
   localparam int         OPER_SENSE     = 10;
   localparam int         OPER_LLF       = 11;
   localparam int         OPER_ULF       = 12;
   localparam int         SUB_BIT        = 1;
   localparam int         LIMIT_BIT      = 3;
   localparam int         QUES_POWER     = 3;
   localparam int         QUES_CAL       = 8;
   localparam int         QUES_SELFTEST  = 9;
   localparam int         POW_OVLD       = 1;
   localparam int         POW_ZERO       = 3;
   localparam int         POW_INVALID    = 5;
   localparam int         STB_DEV        = 1;
   localparam int         STB_ERRQ       = 2;
   localparam int         STB_QUES       = 3;
   localparam int         STB_ESB        = 5;
   localparam int         STB_MSS        = 6;
   localparam int         STB_OPER       = 7;
   localparam logic [4:0] ERRQ_DEPTH     = 5'h10;
endpackage

// >>> rtl/scpi_status_regs.sv
// SCPI status register bank: ten status groups and the IEEE 488.2 set.
// Assumes a command parser issuing one-cycle access and command pulses.
module scpi_status_regs import scpi_status_pkg::*; (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        sys_rst,
   // Status commands
   input  wire logic        cmd_cls,
   input  wire logic        cmd_rst,
   input  wire logic        cmd_preset,
   // Register access
   input  wire logic [3:0]  acc_grp,
   input  wire logic [2:0]  acc_reg,
   input  wire logic        acc_wr,
   input  wire logic        acc_rd,
   input  wire logic [15:0] acc_wdata,
   output logic      [15:0] acc_rdata,
   output logic             acc_rvalid,
   // Equipment sources
   input  wire logic        sensor_attached,
   input  wire logic        sensor_error,
   // Operation sources
   input  wire logic        calibrating,
   input  wire logic        lower_fail,
   input  wire logic        eeprom_reading,
   input  wire logic        trig_waiting,
   input  wire logic        upper_fail,
   // Questionable sources
   input  wire logic        cal_error,
   input  wire logic        overload,
   input  wire logic        zero_needed,
   input  wire logic        data_invalid,
   input  wire logic        selftest_fail,
   // Standard event and error sources
   input  wire logic [7:0]  esr_set,
   input  wire logic        err_push,
   input  wire logic [3:0]  err_class,
   // Status outputs
   output logic      [7:0]  status_byte,
   output logic             service_req
);
   logic [GW-1:0]   cond_in [NGRP];
   logic [GW-1:0]   cond_rd [NGRP];
   logic [GW-1:0]   evt_rd  [NGRP];
   logic [GW-1:0]   en_rd   [NGRP];
   logic [GW-1:0]   ptr_rd  [NGRP];
   logic [GW-1:0]   ntr_rd  [NGRP];
   logic [NGRP-1:0] sum;
   logic [7:0]      esr_q;
   logic [7:0]      ese_q;
   logic [7:0]      sre_q;
   logic [15:0]     errq_en_q;
   logic [4:0]      errq_cnt_q;
   logic [7:0]      stb_d;
   logic [7:0]      stb_q;
   logic [15:0]     rdata_d;
   logic            ieee_hit;
   logic            esr_rd;
   logic            errq_rd;
   logic            err_take;
   logic            en_read_q;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   // Matches one group and register selector
   function automatic logic sel_match(input logic [3:0] ag,
                                      input logic [2:0] ar,
                                      input logic [3:0] grp,
                                      input logic [2:0] rsel);
      return (ag == grp) && (ar == rsel);
   endfunction

   status_group_if gif [NGRP] ();

   // Group instances and their access strobes
   genvar gi;
   generate
      for (gi = 0; gi < NGRP; gi++) begin : g_grp
         assign gif[gi].cond   = cond_in[gi];
         assign gif[gi].wdata  = acc_wdata[GW-1:0];
         assign gif[gi].wr_ptr = acc_wr &&
            sel_match(acc_grp, acc_reg, 4'(gi), R_PTR);
         assign gif[gi].wr_ntr = acc_wr &&
            sel_match(acc_grp, acc_reg, 4'(gi), R_NTR);
         assign gif[gi].wr_en  = acc_wr &&
            sel_match(acc_grp, acc_reg, 4'(gi), R_ENABLE);
         assign gif[gi].rd_evt = acc_rd &&
            sel_match(acc_grp, acc_reg, 4'(gi), R_EVENT);
         assign gif[gi].preset = cmd_preset;
         assign gif[gi].clear  = cmd_cls;
         assign cond_rd[gi]    = gif[gi].cond_q;
         assign evt_rd[gi]     = gif[gi].evt;
         assign en_rd[gi]      = gif[gi].enable;
         assign ptr_rd[gi]     = gif[gi].ptr;
         assign ntr_rd[gi]     = gif[gi].ntr;
         assign sum[gi]        = gif[gi].summary;
         status_group u_grp (
            .clk     (clk),
            .sys_rst (sys_rst),
            .g       (gif[gi])
         );
      end
   endgenerate

   // Condition sources; unlisted bits stay zero
   always_comb begin
      for (int i = 0; i < NGRP; i++) begin
         cond_in[i] = '0;
      end
      cond_in[G_DEV][DEV_SENSOR]     = sensor_attached;
      cond_in[G_DEV][DEV_ERROR]      = sensor_error;
      cond_in[G_OCAL][SUB_BIT]       = calibrating;
      cond_in[G_OLLF][LIMIT_BIT]     = lower_fail;
      cond_in[G_OSNS][SUB_BIT]       = eeprom_reading;
      cond_in[G_OTRG][SUB_BIT]       = trig_waiting;
      cond_in[G_OULF][LIMIT_BIT]     = upper_fail;
      cond_in[G_OPER][OPER_CAL]      = sum[G_OCAL];
      cond_in[G_OPER][OPER_TRIG]     = sum[G_OTRG];
      cond_in[G_OPER][OPER_SENSE]    = sum[G_OSNS];
      cond_in[G_OPER][OPER_LLF]      = sum[G_OLLF];
      cond_in[G_OPER][OPER_ULF]      = sum[G_OULF];
      cond_in[G_QCAL][SUB_BIT]       = cal_error;
      cond_in[G_QPOW][POW_OVLD]      = overload;
      cond_in[G_QPOW][POW_ZERO]      = zero_needed;
      cond_in[G_QPOW][POW_INVALID]   = data_invalid;
      cond_in[G_QUES][QUES_POWER]    = sum[G_QPOW];
      cond_in[G_QUES][QUES_CAL]      = sum[G_QCAL];
      cond_in[G_QUES][QUES_SELFTEST] = selftest_fail;
   end

   // IEEE 488.2 access strobes
   assign ieee_hit = (acc_grp == G_IEEE);
   assign esr_rd   = acc_rd && sel_match(acc_grp, acc_reg, G_IEEE, R_ESR);
   assign errq_rd  = acc_rd && sel_match(acc_grp, acc_reg, G_IEEE, R_ERRQ);
   assign err_take = err_push && errq_en_q[err_class];

   // Standard event register, set wins over read and clear
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         esr_q <= '0;
      end else begin
         esr_q <= ((esr_rd || cmd_cls) ? '0 : esr_q) | esr_set;
      end
   end

   // Standard enables: cleared only at power-on
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ese_q <= '0;
         sre_q <= '0;
      end else if (acc_wr && ieee_hit) begin
         if (acc_reg == R_ESE) begin
            ese_q <= acc_wdata[7:0];
         end
         if (acc_reg == R_SRE) begin
            sre_q <= acc_wdata[7:0] & ~(8'h01 << STB_MSS);
         end
      end
   end

   // Error queue enable
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         errq_en_q <= ERRQ_EN_PRESET;
      end else if (cmd_preset) begin
         errq_en_q <= ERRQ_EN_PRESET;
      end else if (acc_wr && sel_match(acc_grp, acc_reg, G_IEEE,
                                       R_ERRQ_EN)) begin
         errq_en_q <= acc_wdata;
      end
   end

   // Error queue depth count; a read pops one entry
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         errq_cnt_q <= '0;
      end else if (cmd_cls) begin
         errq_cnt_q <= err_take ? 5'h01 : 5'h00;
      end else begin
         case ({err_take && errq_cnt_q != ERRQ_DEPTH,
                errq_rd && errq_cnt_q != '0})
            2'b10:   errq_cnt_q <= errq_cnt_q + 5'h01;
            2'b01:   errq_cnt_q <= errq_cnt_q - 5'h01;
            default: errq_cnt_q <= errq_cnt_q;
         endcase
      end
   end

   // Status byte from group and standard summaries
   always_comb begin
      stb_d           = '0;
      stb_d[STB_DEV]  = sum[G_DEV];
      stb_d[STB_ERRQ] = (errq_cnt_q != '0);
      stb_d[STB_QUES] = sum[G_QUES];
      stb_d[STB_ESB]  = |(esr_q & ese_q);
      stb_d[STB_OPER] = sum[G_OPER];
      stb_d[STB_MSS]  = |(stb_d & sre_q);
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         stb_q <= '0;
      end else if (cmd_cls) begin
         stb_q <= '0;
      end else begin
         stb_q <= stb_d;
      end
   end

   assign status_byte = stb_q;
   assign service_req = stb_q[STB_MSS];

   // Read data selection
   always_comb begin
      rdata_d = '0;
      if (acc_grp < 4'(NGRP)) begin
         case (acc_reg)
            R_COND:   rdata_d = {1'b0, cond_rd[acc_grp]};
            R_EVENT:  rdata_d = {1'b0, evt_rd[acc_grp]};
            R_ENABLE: rdata_d = {1'b0, en_rd[acc_grp]};
            R_PTR:    rdata_d = {1'b0, ptr_rd[acc_grp]};
            R_NTR:    rdata_d = {1'b0, ntr_rd[acc_grp]};
            default:  rdata_d = '0;
         endcase
      end else if (ieee_hit) begin
         case (acc_reg)
            R_STB:     rdata_d = {8'h00, stb_q};
            R_ESR:     rdata_d = {8'h00, esr_q};
            R_ESE:     rdata_d = {8'h00, ese_q};
            R_SRE:     rdata_d = {8'h00, sre_q};
            R_ERRQ:    rdata_d = {11'h000, errq_cnt_q};
            R_ERRQ_EN: rdata_d = errq_en_q;
            default:   rdata_d = '0;
         endcase
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         acc_rdata <= '0;
      end else if (acc_rd) begin
         acc_rdata <= rdata_d;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         acc_rvalid <= 1'b0;
         en_read_q  <= 1'b0;
      end else begin
         acc_rvalid <= acc_rd;
         en_read_q  <= acc_rd && acc_reg == R_ENABLE &&
                       acc_grp < 4'(NGRP);
      end
   end

   // Sensor removal then attach, as seen on the pin
   sequence s_removal;
      sensor_attached ##1 !sensor_attached;
   endsequence

   sequence s_attach;
      !sensor_attached ##1 sensor_attached;
   endsequence

   a_cond_read: assert property (
      sel_match(acc_grp, acc_reg, G_DEV, R_COND) && acc_rd |=>
      acc_rdata == {1'b0, $past(cond_rd[G_DEV])} &&
      cond_rd[G_DEV] == $past(cond_in[G_DEV]))
      else $error("condition read wrong or disturbed");
   a_enable_top: assert property (en_read_q |-> !acc_rdata[15])
      else $error("enable bit 15 not zero");
   a_sensor_remove: assert property (
      (s_removal ##0 ntr_rd[G_DEV][DEV_SENSOR]) |->
      ##[1:2] evt_rd[G_DEV][DEV_SENSOR])
      else $error("sensor removal event missed");
   a_sensor_attach: assert property (
      (s_attach ##0 ptr_rd[G_DEV][DEV_SENSOR]) |->
      ##[1:2] evt_rd[G_DEV][DEV_SENSOR])
      else $error("sensor attach event missed");
   a_sensor_error: assert property (1'b1 |=>
      cond_rd[G_DEV][DEV_ERROR] == $past(sensor_error))
      else $error("error condition bit wrong");
   a_std_enables: assert property (
      (cmd_cls || cmd_rst || cmd_preset) && !acc_wr |=>
      $stable(ese_q) && $stable(sre_q))
      else $error("standard enables disturbed");
   a_queue_clear: assert property (cmd_cls && !err_push |=>
      errq_cnt_q == '0)
      else $error("error queue not cleared");
   a_dev_summary: assert property (!cmd_cls |=>
      stb_q[STB_DEV] == |($past(evt_rd[G_DEV]) & $past(en_rd[G_DEV])))
      else $error("device summary not gated by enable");
   a_stb_clear: assert property (cmd_cls |=> stb_q == '0)
      else $error("status byte not cleared");
   a_unused_bits: assert property (
      (cond_rd[G_DEV] & ~15'h000A) == '0)
      else $error("unused equipment bit set");
endmodule

// >>> rtl/status_group.sv
// One SCPI status group: condition, filters, event and enable.
// Assumes controls are one-cycle pulses synchronous to clk.
module status_group import scpi_status_pkg::*; (
   // Clock and reset
   input  wire logic clk,
   input  wire logic sys_rst,
   // Bank side
   status_group_if.grp g
);
   logic [GW-1:0] set_bits;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   // Edge filtering of the condition
   assign set_bits = (g.cond & ~g.cond_q & g.ptr)
                   | (~g.cond & g.cond_q & g.ntr);
   assign g.summary = |(g.evt & g.enable);

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         g.cond_q <= '0;
      end else begin
         g.cond_q <= g.cond;
      end
   end

   // Filters: only power-on and preset restore them
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         g.ptr <= PTR_PRESET;
         g.ntr <= NTR_PRESET;
      end else if (g.preset) begin
         g.ptr <= PTR_PRESET;
         g.ntr <= NTR_PRESET;
      end else begin
         if (g.wr_ptr) g.ptr <= g.wdata;
         if (g.wr_ntr) g.ntr <= g.wdata;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         g.enable <= EN_PRESET;
      end else if (g.preset) begin
         g.enable <= EN_PRESET;
      end else if (g.wr_en) begin
         g.enable <= g.wdata;
      end
   end

   // New events win over a read or clear in the same cycle
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         g.evt <= '0;
      end else begin
         g.evt <= ((g.rd_evt || g.clear) ? '0 : g.evt) | set_bits;
      end
   end

   a_event_latch: assert property ((set_bits != '0) |=>
      ((g.evt & $past(set_bits)) == $past(set_bits)))
      else $error("filtered edge did not latch event");
   a_filter_block: assert property (1'b1 |=>
      ((g.evt & ~$past(g.evt) & ~($past(g.ptr) | $past(g.ntr))) == '0))
      else $error("event set without filter bit");
   a_read_clear: assert property ((g.rd_evt && set_bits == '0) |=>
      (g.evt == '0))
      else $error("event register not cleared by read");
   a_preset_vals: assert property (g.preset |=>
      (g.ptr == PTR_PRESET && g.ntr == NTR_PRESET && g.enable == EN_PRESET))
      else $error("preset values wrong");
   a_filter_keep: assert property ((g.clear && !g.preset && !g.wr_ptr) |=>
      $stable(g.ptr))
      else $error("clear disturbed positive filter");
endmodule

// >>> rtl/status_group_if.sv
// Signals between the bank and one status group.
// Assumes the bank drives controls and the group drives register state.
interface status_group_if;
   import scpi_status_pkg::*;
   logic [GW-1:0] cond;
   logic [GW-1:0] wdata;
   logic          wr_ptr;
   logic          wr_ntr;
   logic          wr_en;
   logic          rd_evt;
   logic          preset;
   logic          clear;
   logic [GW-1:0] ptr;
   logic [GW-1:0] ntr;
   logic [GW-1:0] enable;
   logic [GW-1:0] evt;
   logic [GW-1:0] cond_q;
   logic          summary;
   modport grp (input cond, wdata, wr_ptr, wr_ntr, wr_en, rd_evt, preset,
                clear, output ptr, ntr, enable, evt, cond_q, summary);
   modport ctl (output cond, wdata, wr_ptr, wr_ntr, wr_en, rd_evt, preset,
                clear, input ptr, ntr, enable, evt, cond_q, summary);
endinterface

// >>> tb/host_model.sv
// Host model: issues register accesses and status commands to the bank.
// Assumes the bank samples strobes on the rising edge of clk.
module host_model import scpi_status_pkg::*; (
   // Clock
   input  wire logic        clk,
   // Requests
   output logic      [3:0]  acc_grp,
   output logic      [2:0]  acc_reg,
   output logic             acc_wr,
   output logic             acc_rd,
   output logic      [15:0] acc_wdata,
   output logic             cmd_cls,
   output logic             cmd_rst,
   output logic             cmd_preset,
   // Answers
   input  wire logic [15:0] acc_rdata,
   input  wire logic        acc_rvalid
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      {acc_grp, acc_reg, acc_wr, acc_rd} = 9'h000;
      acc_wdata = 16'h0000;
      {cmd_cls, cmd_rst, cmd_preset} = 3'h0;
   end
   // One write, strobe held for one rising edge
   task automatic wr(input logic [3:0] g, input logic [2:0] r,
                     input logic [15:0] d);
      @(negedge clk);
      acc_grp = g;
      acc_reg = r;
      acc_wdata = d;
      acc_wr = 1'b1;
      @(negedge clk);
      acc_wr = 1'b0;
      acc_reg = ~r;
      acc_wdata = ~d;
   endtask
   // One read; X returned when no valid answer came
   task automatic rd(input logic [3:0] g, input logic [2:0] r,
                     output logic [15:0] d);
      @(negedge clk);
      acc_grp = g;
      acc_reg = r;
      acc_rd = 1'b1;
      @(negedge clk);
      acc_rd = 1'b0;
      acc_reg = ~r;
      d = (acc_rvalid === 1'b1) ? acc_rdata : 16'hXXXX;
   endtask
   // Command pulse: 0 clear, 1 reset, 2 preset
   task automatic cmd(input logic [1:0] k);
      @(negedge clk);
      cmd_cls = (k == 2'h0);
      cmd_rst = (k == 2'h1);
      cmd_preset = (k == 2'h2);
      @(negedge clk);
      {cmd_cls, cmd_rst, cmd_preset} = 3'h0;
   endtask
endmodule

// >>> tb/scpi_status_regs_tb_top.sv
// Self-checking bench for the status register bank.
// Assumes host_model drives the access port and commands.
module scpi_status_regs_tb_top import scpi_status_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk, sys_rst, cmd_cls, cmd_rst, cmd_preset, acc_wr, acc_rd;
   logic [3:0]  acc_grp, err_class;
   logic [2:0]  acc_reg;
   logic [15:0] acc_wdata, acc_rdata, d, p, n, o;
   logic        acc_rvalid, sensor_attached, sensor_error, calibrating;
   logic        lower_fail, eeprom_reading, trig_waiting, upper_fail;
   logic        cal_error, overload, zero_needed, data_invalid;
   logic        selftest_fail, err_push, service_req;
   logic [7:0]  esr_set, status_byte, es;
   int          n_mismatch, n_checks, qn;
   scpi_status_regs DUT (.clk(clk), .sys_rst(sys_rst), .cmd_cls(cmd_cls),
      .cmd_rst(cmd_rst), .cmd_preset(cmd_preset), .acc_grp(acc_grp),
      .acc_reg(acc_reg), .acc_wr(acc_wr), .acc_rd(acc_rd),
      .acc_wdata(acc_wdata), .acc_rdata(acc_rdata), .acc_rvalid(acc_rvalid),
      .sensor_attached(sensor_attached), .sensor_error(sensor_error),
      .calibrating(calibrating), .lower_fail(lower_fail),
      .eeprom_reading(eeprom_reading), .trig_waiting(trig_waiting),
      .upper_fail(upper_fail), .cal_error(cal_error), .overload(overload),
      .zero_needed(zero_needed), .data_invalid(data_invalid),
      .selftest_fail(selftest_fail), .esr_set(esr_set), .err_push(err_push),
      .err_class(err_class), .status_byte(status_byte),
      .service_req(service_req));
   host_model host (.clk(clk), .acc_grp(acc_grp), .acc_reg(acc_reg),
      .acc_wr(acc_wr), .acc_rd(acc_rd), .acc_wdata(acc_wdata),
      .cmd_cls(cmd_cls), .cmd_rst(cmd_rst), .cmd_preset(cmd_preset),
      .acc_rdata(acc_rdata), .acc_rvalid(acc_rvalid));
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic rc(input logic [3:0] g, input logic [2:0] r,
                     input logic [15:0] exp);
      logic [15:0] v;
      host.rd(g, r, v);
      chk(v, exp);
   endtask
   task automatic done(input string s);
      $display("test %s done", s);
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // Expected event bits from old and new condition
   function automatic logic [15:0] evt(input logic [15:0] a, b, fp, fn);
      return ((~a & b & fp) | (a & ~b & fn)) & 16'h7FFF;
   endfunction
   function automatic logic [15:0] cnd();
      return {12'h000, sensor_error, 1'b0, sensor_attached, 1'b0};
   endfunction
   task automatic chk_preset();
      for (int g = 0; g < NGRP; g++) begin
         rc(4'(g), R_PTR, 16'h7FFF);
         rc(4'(g), R_NTR, 16'h0000);
         rc(4'(g), R_ENABLE, 16'h0000);
      end
   endtask
   initial begin
      repeat (40000) @(posedge clk);
      n_mismatch++;
      $display("mismatch at %0t: timeout", $time);
      end_sim();
   end
   initial begin
      n_mismatch = 0;
      n_checks = 0;
      sys_rst = 1'b1;
      {sensor_attached, sensor_error, calibrating, lower_fail} = 4'h0;
      {eeprom_reading, trig_waiting, upper_fail, cal_error} = 4'h0;
      {overload, zero_needed, data_invalid, selftest_fail} = 4'h0;
      {esr_set, err_push, err_class} = 13'h0000;
      void'($urandom(32'hA8963B71));
      repeat (13) @(negedge clk);
      sys_rst = 1'b0;
      chk_preset();
      rc(G_IEEE, R_ESE, 16'h0000);
      rc(G_IEEE, R_SRE, 16'h0000);
      rc(G_IEEE, R_STB, 16'h0000);
      rc(G_IEEE, R_ERRQ_EN, 16'hFFFF);
      done("reset");
      for (int g = 0; g < NGRP; g++)
         for (int r = 2; r < 5; r++) begin
            host.wr(4'(g), 3'(r), 16'hFFFF);
            rc(4'(g), 3'(r), 16'h7FFF);
         end
      host.cmd(2'h2);
      chk_preset();
      done("top bit");
      for (int i = 0; i < 48; i++) begin
         p = (i < 4) ? (i[1] ? 16'h000A : 16'h0000) : 16'($urandom);
         n = (i < 4) ? (i[0] ? 16'h000A : 16'h0000) : 16'($urandom);
         o = cnd();
         host.wr(G_DEV, R_PTR, p);
         host.wr(G_DEV, R_NTR, n);
         host.rd(G_DEV, R_EVENT, d);
         if (i < 4)
            {sensor_error, sensor_attached} = ~{sensor_error, sensor_attached};
         else
            {sensor_error, sensor_attached} = 2'($urandom);
         {calibrating, lower_fail, eeprom_reading, trig_waiting, upper_fail,
          cal_error, overload, zero_needed, data_invalid,
          selftest_fail} = 10'($urandom);
         repeat (2) @(negedge clk);
         rc(G_DEV, R_COND, cnd());
         rc(G_DEV, R_EVENT, evt(o, cnd(), p, n));
         o = {10'h000, data_invalid, 1'b0, zero_needed, 1'b0, overload, 1'b0};
         rc(G_QPOW, R_COND, o);
         rc(G_DEV, R_EVENT, 16'h0000);
      end
      {calibrating, lower_fail, eeprom_reading, trig_waiting, upper_fail,
       cal_error, overload, zero_needed, data_invalid, selftest_fail} = 10'h000;
      repeat (4) @(negedge clk);
      host.cmd(2'h0);
      host.cmd(2'h2);
      done("filters");
      host.wr(G_DEV, R_ENABLE, 16'h000A);
      host.wr(G_DEV, R_NTR, 16'h000A);
      host.wr(G_IEEE, R_ESE, 16'h00FF);
      sensor_attached = ~sensor_attached;
      esr_set = 8'h01;
      err_push = 1'b1;
      @(negedge clk);
      esr_set = 8'h00;
      err_push = 1'b0;
      repeat (3) @(negedge clk);
      chk({8'h00, status_byte}, 16'h0026);
      host.cmd(2'h1);
      rc(G_DEV, R_ENABLE, 16'h000A);
      rc(G_DEV, R_NTR, 16'h000A);
      rc(G_IEEE, R_ESE, 16'h00FF);
      chk({8'h00, status_byte}, 16'h0026);
      host.cmd(2'h2);
      rc(G_DEV, R_ENABLE, 16'h0000);
      rc(G_DEV, R_NTR, 16'h0000);
      rc(G_IEEE, R_ESE, 16'h00FF);
      chk({8'h00, status_byte}, 16'h0024);
      host.wr(G_DEV, R_ENABLE, 16'h0002);
      repeat (3) @(negedge clk);
      chk({8'h00, status_byte}, 16'h0026);
      host.cmd(2'h0);
      repeat (3) @(negedge clk);
      chk({8'h00, status_byte}, 16'h0000);
      rc(G_DEV, R_EVENT, 16'h0000);
      rc(G_IEEE, R_ESR, 16'h0000);
      rc(G_IEEE, R_ERRQ, 16'h0000);
      rc(G_IEEE, R_ESE, 16'h00FF);
      rc(G_DEV, R_ENABLE, 16'h0002);
      rc(G_DEV, R_PTR, 16'h7FFF);
      done("commands");
      o = 16'h0000;
      for (int k = 0; k < 3; k++) begin
         host.wr((k == 0) ? G_OCAL : (k == 1) ? G_OTRG : G_OSNS, R_ENABLE,
                 16'h0002);
         case (k)
            0: calibrating = 1'b1;
            1: trig_waiting = 1'b1;
            default: eeprom_reading = 1'b1;
         endcase
         o = o | ((k == 0) ? 16'h0001 : (k == 1) ? 16'h0020 : 16'h0400);
         repeat (4) @(negedge clk);
         rc(G_OPER, R_COND, o);
      end
      done("operation");
      p = 16'($urandom);
      es = 8'h00;
      qn = 0;
      host.wr(G_IEEE, R_ERRQ_EN, p);
      host.wr(G_IEEE, R_SRE, 16'h00FF);
      rc(G_IEEE, R_SRE, 16'h00BF);
      for (int j = 0; j < 24; j++) begin
         @(negedge clk);
         err_push = 1'($urandom);
         err_class = 4'($urandom);
         esr_set = 8'($urandom);
         es = es | esr_set;
         if (err_push && p[err_class] && qn < 16) qn++;
      end
      @(negedge clk);
      {esr_set, err_push, err_class} = 13'h0000;
      repeat (3) @(negedge clk);
      o = {9'h000, (es != 8'h00) || (qn != 0), es != 8'h00, 2'b00,
           qn != 0, 2'b00};
      chk({8'h00, status_byte}, o);
      chk({15'h0000, service_req}, {15'h0000, o[6]});
      rc(G_IEEE, R_ERRQ, 16'(qn));
      rc(G_IEEE, R_ERRQ, 16'((qn > 0) ? qn - 1 : 0));
      rc(G_IEEE, R_ESR, {8'h00, es});
      host.cmd(2'h0);
      repeat (3) @(negedge clk);
      chk({15'h0000, service_req}, 16'h0000);
      rc(G_IEEE, R_ERRQ, 16'h0000);
      done("queue");
      end_sim();
   end
endmodule
